// *** bsm_control.sv ***
// module: strap decoding, setpoint ramping and operating mode resolution
// Notes on behaviour
// - msb of each strap read with both probe switches open.
// - msb 0: close first switch, lsb is sensed level.
// - msb 1: close second switch, lsb is sensed level.
// - frequency strap code picks 1.5, 2.25, 2.5 or 3 MHz.
// - range field picks base and step size.
// - range defaults to 0.4 V base, 5 mV steps.
// - new range applies only after a following setpoint write, or at the next enable.
// - 0.8 V reference for range 0b11, otherwise 0.4 V.
// - variants without host bus keep range fixed at default.
// - target is base plus code times step.
// - voltage strap loads default setpoint code at init.
// - voltage strap also gives the host bus target address.
// - writes after soft-start began wait until it finishes.
// - soft-start ramps to latched code, then to the newer one.
// - writes while disabled apply at the next enable.
// - writes during any ramp wait until it completes.
// - setpoint changes step one code per slew interval.
// - mode pin high forces pwm, low gives power save.
// - valid sync clock aligns switching and forces pwm.
// - forced pwm is mode pin OR forced bit OR sync lock OR spread spectrum OR secondary.
// - on secondaries the mode pin is the switching clock.
// - spread spectrum forces pwm regardless of forced bit.
// - start-up ramp always uses discontinuous conduction.
module bsm_control
  import bsm_pkg::*;
#(
  parameter bit HAS_HOST = 1'b1 // variant with the two-wire host interface
)(
  input  wire logic              clock,         // 100 MHz clock
  input  wire logic              rstn,          // async reset, active low
  input  wire logic              stratStart,    // begin initialization pulse
  input  wire logic              freqStrapIn,   // sensed level of frequency strap
  input  wire logic              voltStrapIn,   // sensed level of voltage strap
  input  wire logic              enable,        // converter enable input
  input  wire logic              softDone,      // analog soft-start finished
  input  wire logic              modeSyncIn,    // mode/sync pin level
  input  wire logic              secondary,     // device is a stack secondary
  input  wire logic              spreadEn,      // spread spectrum enabled
  input  wire bsm_pkg::bsm_host_s host,         // host register writes
  output logic                   probe1Close,   // first probe switch closed
  output logic                   probe2Close,   // second probe switch closed
  output logic                   initDone,      // initialization complete
  output logic [11:0]            fswKhz,        // selected switching frequency
  output logic [6:0]             targetAddr,    // host bus target address
  output logic                   syncClkOut,    // switching clock follows pin
  output logic [7:0]             setpointCode,  // programmed setpoint readback
  output logic                   ramping,       // a voltage ramp is running
  output bsm_pkg::bsm_stage_s    stage          // power stage controls
);
  import bsm_pkg::*;

  typedef struct packed {
    bsm_state_e  st;
    logic [7:0]  cnt;
    logic        strapSel;   // 0 frequency strap, 1 voltage strap
    logic [1:0]  fCode;
    logic [1:0]  vCode;
    logic        p1;
    logic        p2;
    logic        done;
    logic [11:0] fsw;
    logic [6:0]  addr;
    // programmed values
    logic [7:0]  progSet;
    logic [1:0]  progRange;
    logic [1:0]  progSlew;
    logic [1:0]  progSs;
    logic        progForced;
    logic        setPend;    // setpoint write pending application
    // active values
    logic [7:0]  goal;
    logic [7:0]  code;
    logic [1:0]  range;
    logic [1:0]  slew;
    logic [1:0]  ss;
    logic [10:0] slewCnt;
    logic        ramp;       // soft-start or slew ramp running
    // sync detection
    logic        syncPrev;
    logic [7:0]  winCnt;
    logic [2:0]  edges;
    logic        syncOk;
    bsm_stage_s  out;
  } bsm_ctl_s;

  bsm_ctl_s s_reg, s_next;
  logic [21:0] stepUv;
  logic [10:0] slewCyc;

  always_comb
  begin
    case (s_reg.slew)
      2'h0:    slewCyc = SLEW0_CYC;
      2'h1:    slewCyc = SLEW1_CYC;
      2'h2:    slewCyc = SLEW2_CYC;
      default: slewCyc = SLEW3_CYC;
    endcase
  end

  always_comb
  begin
    s_next = s_reg;
    // host writes land in programmed copies; the forced bit acts at once, the rest steer the block only in the run state or at enable
    if (host.wrControl && HAS_HOST)
    begin
      s_next.progRange = host.range;
      s_next.progSlew = host.slew;
      s_next.progSs = host.softstart;
      s_next.progForced = host.forced;
    end
    if (host.wrSetpoint)
    begin
      s_next.progSet = host.setpoint;
      s_next.setPend = 1'b1;
    end
    if (!HAS_HOST)
      s_next.progRange = RANGE_DEF;
    // sync clock detection
    s_next.syncPrev = modeSyncIn;
    if (s_reg.winCnt == SYNC_WIN_CYC - 8'h1)
    begin
      s_next.winCnt = 8'h0;
      s_next.syncOk = (s_reg.edges >= SYNC_EDGES);
      s_next.edges = 3'h0;
    end
    else
    begin
      s_next.winCnt = s_reg.winCnt + 8'h1;
      if ((modeSyncIn != s_reg.syncPrev) && (s_reg.edges != 3'h7))
        s_next.edges = s_reg.edges + 3'h1;
    end
    case (s_reg.st)
      BSM_ST_MSB:
      begin
        s_next.p1 = 1'b0;
        s_next.p2 = 1'b0;
        if (s_reg.cnt == SETTLE_CYC)
        begin
          s_next.cnt = 8'h0;
          s_next.st = BSM_ST_LSB;
          if (!s_reg.strapSel)
            s_next.fCode[1] = freqStrapIn;
          else
            s_next.vCode[1] = voltStrapIn;
          s_next.p1 = s_reg.strapSel ? !voltStrapIn : !freqStrapIn;
          s_next.p2 = s_reg.strapSel ? voltStrapIn : freqStrapIn;
        end
        else
          s_next.cnt = s_reg.cnt + 8'h1;
      end
      BSM_ST_LSB:
      begin
        if (s_reg.cnt == SETTLE_CYC)
        begin
          s_next.cnt = 8'h0;
          s_next.p1 = 1'b0;
          s_next.p2 = 1'b0;
          // lsb is the level sensed with the probe closed
          if (!s_reg.strapSel)
          begin
            s_next.fCode[0] = freqStrapIn;
            s_next.strapSel = 1'b1;
            s_next.st = BSM_ST_MSB;
          end
          else
          begin
            s_next.vCode[0] = voltStrapIn;
            s_next.st = BSM_ST_IDLE;
            s_next.done = 1'b1;
            case (s_reg.fCode)
              2'h0:    s_next.fsw = FSW0_KHZ;
              2'h1:    s_next.fsw = FSW1_KHZ;
              2'h2:    s_next.fsw = FSW2_KHZ;
              default: s_next.fsw = FSW3_KHZ;
            endcase
            s_next.addr = ADDR_BASE | {5'h0, s_reg.vCode[1], voltStrapIn};
            case ({s_reg.vCode[1], voltStrapIn})
              2'h0:    s_next.progSet = VSET_GND;
              2'h3:    s_next.progSet = VSET_VIN;
              default: s_next.progSet = VSET_GND;
            endcase
            s_next.progRange = RANGE_DEF;
            s_next.setPend = 1'b1;
          end
        end
        else
          s_next.cnt = s_reg.cnt + 8'h1;
      end
      BSM_ST_IDLE:
      begin
        // values written while disabled are taken at enable
        s_next.code = 8'h0;
        if (enable)
        begin
          s_next.goal = s_next.progSet;
          s_next.range = s_next.progRange;
          s_next.slew = s_next.progSlew;
          s_next.ss = s_next.progSs;
          s_next.setPend = 1'b0;
          s_next.st = BSM_ST_SOFT;
        end
      end
      BSM_ST_SOFT:
      begin
        s_next.code = s_reg.goal;
        if (!enable)
          s_next.st = BSM_ST_IDLE;
        else if (softDone)
          s_next.st = BSM_ST_RUN;
      end
      BSM_ST_RUN:
      begin
        s_next.slew = s_reg.progSlew;
        s_next.ss = s_reg.progSs;
        if (!enable)
          s_next.st = BSM_ST_IDLE;
        else if (s_reg.setPend)
        begin
          s_next.goal = s_reg.progSet;
          s_next.range = s_reg.progRange;
          s_next.setPend = host.wrSetpoint;
          s_next.slewCnt = 11'h0;
          s_next.st = BSM_ST_SLEW;
        end
      end
      BSM_ST_SLEW:
      begin
        if (!enable)
          s_next.st = BSM_ST_IDLE;
        else if (s_reg.code == s_reg.goal)
          s_next.st = BSM_ST_RUN;
        else if (s_reg.slewCnt >= slewCyc - 11'h1)
        begin
          s_next.slewCnt = 11'h0;
          s_next.code = (s_reg.goal > s_reg.code) ? s_reg.code + 8'h1
                                                  : s_reg.code - 8'h1;
        end
        else
          s_next.slewCnt = s_reg.slewCnt + 11'h1;
      end
      default: s_next.st = BSM_ST_MSB;
    endcase
    if (stratStart)
    begin
      s_next.st = BSM_ST_MSB;
      s_next.cnt = 8'h0;
      s_next.strapSel = 1'b0;
      s_next.done = 1'b0;
    end
    // step follows the range being registered so target and range change together
    case (s_next.range)
      RANGE_1P25: stepUv = STEP0_UV;
      RANGE_2P5:  stepUv = STEP1_UV;
      RANGE_5:    stepUv = STEP2_UV;
      default:    stepUv = STEP3_UV;
    endcase
    s_next.ramp = (s_next.st == BSM_ST_SOFT) || (s_next.st == BSM_ST_SLEW);
    s_next.out.code = s_next.code;
    s_next.out.range = s_next.range;
    s_next.out.refHigh = (s_next.range == RANGE_10);
    s_next.out.targetUv = ((s_next.range == RANGE_10) ? BASE_HI_UV : BASE_LO_UV)
                          + 22'(s_next.code * stepUv);
    s_next.out.syncLock = s_next.syncOk || secondary;
    s_next.out.forcedPwm = modeSyncIn || s_next.progForced || s_next.syncOk
                           || spreadEn || secondary;
    s_next.out.dcmOnly = (s_next.st == BSM_ST_SOFT);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
      s_reg.st <= BSM_ST_MSB;
      s_reg.progRange <= RANGE_DEF;
      s_reg.range <= RANGE_DEF;
      s_reg.out.range <= RANGE_DEF;
      s_reg.progSs <= SS_DEF;
      s_reg.progSlew <= SLEW_DEF;
    end
    else
      s_reg <= s_next;
  end

  assign probe1Close = s_reg.p1;
  assign probe2Close = s_reg.p2;
  assign initDone = s_reg.done;
  assign fswKhz = s_reg.fsw;
  assign targetAddr = s_reg.addr;
  assign syncClkOut = s_reg.out.syncLock;
  assign setpointCode = s_reg.progSet;
  assign ramping = s_reg.ramp;
  assign stage = s_reg.out;

  AST_REF_HIGH: assert property (@(posedge clock) disable iff (!rstn)
    stage.refHigh == (stage.range == RANGE_10)) else $error("ref select wrong");
  AST_DCM_SOFT: assert property (@(posedge clock) disable iff (!rstn)
    (s_reg.st == BSM_ST_SOFT) |-> ##1 (stage.dcmOnly || s_reg.st != BSM_ST_SOFT))
    else $error("soft start not dcm");
  AST_FORCED_OR: assert property (@(posedge clock) disable iff (!rstn)
    (modeSyncIn || HAS_HOST && host.wrControl && host.forced) |=> stage.forcedPwm)
    else $error("forced pwm missing");
  AST_ONE_STEP: assert property (@(posedge clock) disable iff (!rstn)
    (s_reg.st == BSM_ST_SLEW && $past(s_reg.st) == BSM_ST_SLEW)
    |-> (s_reg.code - $past(s_reg.code) <= 8'h1 || $past(s_reg.code) - s_reg.code <= 8'h1))
    else $error("slew step too big");
  AST_SOFT_HOLD: assert property (@(posedge clock) disable iff (!rstn)
    (s_reg.st == BSM_ST_SOFT && $past(s_reg.st) == BSM_ST_SOFT) |-> $stable(s_reg.goal))
    else $error("goal changed in soft start");
  AST_RANGE_HOLD: assert property (@(posedge clock) disable iff (!rstn)
    (s_reg.st == BSM_ST_RUN && !s_reg.setPend) |=> $stable(s_reg.range) || s_reg.st != BSM_ST_RUN)
    else $error("range applied without setpoint write");
  AST_PROBE_EXCL: assert property (@(posedge clock) disable iff (!rstn)
    !(s_reg.p1 && s_reg.p2)) else $error("both probes closed");
  AST_MSB_OPEN: assert property (@(posedge clock) disable iff (!rstn)
    (s_reg.st == BSM_ST_MSB && s_reg.cnt != 8'h0) |-> (!s_reg.p1 && !s_reg.p2))
    else $error("probe closed during msb");
endmodule

// *** bsm_control_test.sv ***
// testbench for the setpoint and mode control block
module bsm_control_test;
  import bsm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock = 1'b0;
  logic       rstn = 1'b0;
  logic       stratStart = 1'b0;
  logic       freqStrapIn;
  logic       voltStrapIn;
  logic       enable = 1'b0;
  logic       softDone = 1'b0;
  logic       modeSyncIn = 1'b0;
  logic       secondary = 1'b0;
  logic       spreadEn = 1'b0;
  bsm_host_s  host = '0;
  logic       probe1Close;
  logic       probe2Close;
  logic       initDone;
  logic [11:0] fswKhz;
  logic [6:0] targetAddr;
  logic       syncClkOut;
  logic [7:0] setpointCode;
  logic       ramping;
  bsm_stage_s stage;
  bsm_stage_s fixedStage;
  logic [1:0] fCode = 2'h0;
  logic [1:0] vCode = 2'h0;
  int         mismatches = 0;
  int         compares = 0;

  always #5 clock = ~clock;

  bsm_control dut (.clock(clock), .rstn(rstn), .stratStart(stratStart),
    .freqStrapIn(freqStrapIn), .voltStrapIn(voltStrapIn), .enable(enable),
    .softDone(softDone), .modeSyncIn(modeSyncIn), .secondary(secondary),
    .spreadEn(spreadEn), .host(host), .probe1Close(probe1Close),
    .probe2Close(probe2Close), .initDone(initDone), .fswKhz(fswKhz),
    .targetAddr(targetAddr), .syncClkOut(syncClkOut), .setpointCode(setpointCode),
    .ramping(ramping), .stage(stage));
  // variant without host bus: range must stay at its default
  bsm_control #(.HAS_HOST(1'b0)) fixedDut (.clock(clock), .rstn(rstn), .stratStart(stratStart),
    .freqStrapIn(freqStrapIn), .voltStrapIn(voltStrapIn), .enable(enable),
    .softDone(softDone), .modeSyncIn(modeSyncIn), .secondary(secondary),
    .spreadEn(spreadEn), .host(host), .probe1Close(), .probe2Close(), .initDone(),
    .fswKhz(), .targetAddr(), .syncClkOut(), .setpointCode(), .ramping(),
    .stage(fixedStage));
  bsm_strap_model fStrap (.strapCode(fCode), .probe1Close(probe1Close),
    .probe2Close(probe2Close), .level(freqStrapIn));
  bsm_strap_model vStrap (.strapCode(vCode), .probe1Close(probe1Close),
    .probe2Close(probe2Close), .level(voltStrapIn));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_val(input string name, input logic [21:0] exp, input logic [21:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic timeout(input string name);
    mismatches++;
    $display("ERROR %s expected completion seen timeout", name);
    report_and_stop();
  endtask

  task automatic wr_ctrl(input logic [1:0] rng, input logic [1:0] slw, input logic frc);
    host.range = rng;
    host.slew = slw;
    host.softstart = SS_DEF;
    host.forced = frc;
    host.wrControl = 1'b1;
    tick();
    host.wrControl = 1'b0;
  endtask

  task automatic wr_set(input logic [7:0] code);
    host.setpoint = code;
    host.wrSetpoint = 1'b1;
    tick();
    host.wrSetpoint = 1'b0;
  endtask

  task automatic wait_code(input logic [7:0] goal, input int limit);
    int i;
    for (i = 0; i < limit && stage.code !== goal; i++)
      tick();
    if (stage.code !== goal)
      timeout("stage.code");
  endtask

  task automatic wait_idle();
    int i;
    tick(3);
    for (i = 0; i < 3000 && ramping !== 1'b0; i++)
      tick();
    chk_bit("ramping", 1'b0, ramping);
  endtask

  task automatic test_strap();
    logic [7:0] def;
    for (int i = 0; i < 4; i++)
    begin
      fCode = 2'(i);
      vCode = 2'(3 - i);
      if (i == 1 || i == 2)
      begin
        rstn = 1'b0;
        tick(10);
        rstn = 1'b1;
      end
      else if (i == 3)
      begin
        stratStart = 1'b1;
        tick();
        stratStart = 1'b0;
      end
      tick(150);
      chk_bit("initDone", 1'b1, initDone);
      chk_val("fswKhz",
              22'(i == 0 ? FSW0_KHZ : i == 1 ? FSW1_KHZ : i == 2 ? FSW2_KHZ : FSW3_KHZ),
              22'(fswKhz));
      def = (vCode == 2'h3) ? VSET_VIN : VSET_GND;
      chk_val("setpointCode", 22'(def), 22'(setpointCode));
      chk_val("targetAddr", 22'(ADDR_BASE | 7'(vCode)), 22'(targetAddr));
      chk_val("stage.range", 22'(RANGE_DEF), 22'(stage.range));
      chk_bit("stage.refHigh", 1'b0, stage.refHigh);
    end
    $display("test strap done");
  endtask

  task automatic test_soft();
    wr_set(8'h50);
    enable = 1'b1;
    tick(3);
    chk_bit("ramping", 1'b1, ramping);
    chk_bit("stage.dcmOnly", 1'b1, stage.dcmOnly);
    wr_set(8'h60);
    tick(5);
    chk_val("stage.code", 22'h50, 22'(stage.code));
    softDone = 1'b1;
    tick();
    softDone = 1'b0;
    wait_code(8'h60, 2000);
    wait_idle();
    chk_bit("stage.dcmOnly", 1'b0, stage.dcmOnly);
    $display("test soft done");
  endtask

  task automatic test_slew();
    logic [7:0] start;
    logic [7:0] goal;
    logic [10:0] exp;
    int gap;
    for (int n = 0; n < 4; n++)
    begin
      wr_ctrl(RANGE_DEF, 2'(n), 1'b0);
      start = stage.code;
      goal = (n % 2 == 0) ? start + 8'h02 : start - 8'h02;
      exp = n == 0 ? SLEW0_CYC : n == 1 ? SLEW1_CYC : n == 2 ? SLEW2_CYC : SLEW3_CYC;
      wr_set(goal);
      tick(2);
      chk_bit("ramping", 1'b1, ramping);
      wait_code((n % 2 == 0) ? start + 8'h01 : start - 8'h01, 1200);
      for (gap = 0; gap < 1200 && stage.code !== goal; gap++)
        tick();
      chk_val("slew gap", 22'(exp), 22'(gap));
      wait_idle();
      chk_val("stage.code", 22'(goal), 22'(stage.code));
    end
    $display("test slew done");
  endtask

  task automatic test_range();
    logic [1:0] rng [4] = '{2'h3, 2'h0, 2'h1, 2'h2};
    logic [1:0] prev;
    logic [21:0] base;
    logic [21:0] step;
    prev = stage.range;
    for (int i = 0; i < 4; i++)
    begin
      wr_ctrl(rng[i], 2'h0, 1'b0);
      tick(5);
      chk_val("stage.range held", 22'(prev), 22'(stage.range));
      wr_set(setpointCode);
      wait_idle();
      chk_val("stage.range", 22'(rng[i]), 22'(stage.range));
      chk_val("fixedStage.range", 22'(RANGE_DEF), 22'(fixedStage.range));
      chk_bit("stage.refHigh", rng[i] == RANGE_10, stage.refHigh);
      base = (rng[i] == RANGE_10) ? BASE_HI_UV : BASE_LO_UV;
      step = rng[i] == 2'h0 ? STEP0_UV : rng[i] == 2'h1 ? STEP1_UV
           : rng[i] == 2'h2 ? STEP2_UV : STEP3_UV;
      chk_val("stage.targetUv", base + 22'(stage.code) * step, stage.targetUv);
      prev = rng[i];
    end
    $display("test range done");
  endtask

  task automatic test_hold();
    logic [7:0] c;
    c = stage.code;
    wr_ctrl(RANGE_DEF, 2'h3, 1'b0);
    wr_set(c + 8'h01);
    tick(10);
    wr_set(c + 8'h03);
    wait_code(c + 8'h01, 1100);
    // the first ramp must end before the held write starts a new one
    tick();
    chk_bit("ramping", 1'b0, ramping);
    wait_code(c + 8'h03, 2600);
    chk_val("setpointCode", 22'(c + 8'h03), 22'(setpointCode));
    wait_idle();
    wr_ctrl(RANGE_DEF, 2'h0, 1'b0);
    $display("test hold done");
  endtask

  task automatic test_mode();
    logic [3:0] b;
    for (int i = 0; i < 16; i++)
    begin
      b = 4'(i);
      wr_ctrl(RANGE_DEF, 2'h0, b[1]);
      // mode pin on the top bit so it toggles once and never looks like a clock
      modeSyncIn = b[3];
      spreadEn = b[2];
      secondary = b[0];
      tick(3);
      chk_bit("stage.forcedPwm", |b, stage.forcedPwm);
      chk_bit("syncClkOut", b[0], syncClkOut);
    end
    wr_ctrl(RANGE_DEF, 2'h0, 1'b0);
    spreadEn = 1'b0;
    secondary = 1'b0;
    // toggle over more than two windows so one window lies wholly inside
    for (int i = 0; i < 44; i++)
    begin
      modeSyncIn = ~modeSyncIn;
      tick(10);
    end
    chk_bit("stage.syncLock", 1'b1, stage.syncLock);
    chk_bit("syncClkOut", 1'b1, syncClkOut);
    chk_bit("stage.forcedPwm", 1'b1, stage.forcedPwm);
    modeSyncIn = 1'b0;
    tick(2 * int'(SYNC_WIN_CYC) + 20);
    chk_bit("stage.syncLock", 1'b0, stage.syncLock);
    chk_bit("stage.forcedPwm", 1'b0, stage.forcedPwm);
    $display("test mode done");
  endtask

  initial
  begin
    tick(10);
    rstn = 1'b1;
    test_strap();
    test_soft();
    test_slew();
    test_range();
    test_hold();
    test_mode();
    report_and_stop();
  end
endmodule

// *** bsm_pkg.sv ***
// package: constants and carrier types for the setpoint and mode control block
package bsm_pkg;
  localparam int CLK_MHZ = 100;
  // slew step intervals in ns per code step
  localparam int SLEW0_NS = 500;
  localparam int SLEW1_NS = 1000;
  localparam int SLEW2_NS = 5000;
  localparam int SLEW3_NS = 10000;
  localparam logic [10:0] SLEW0_CYC = 11'(SLEW0_NS * CLK_MHZ / 1000);
  localparam logic [10:0] SLEW1_CYC = 11'(SLEW1_NS * CLK_MHZ / 1000);
  localparam logic [10:0] SLEW2_CYC = 11'(SLEW2_NS * CLK_MHZ / 1000);
  localparam logic [10:0] SLEW3_CYC = 11'(SLEW3_NS * CLK_MHZ / 1000);
  // strap probe settling time
  localparam int SETTLE_NS = 200;
  localparam logic [7:0] SETTLE_CYC = 8'((SETTLE_NS * CLK_MHZ + 999) / 1000);
  // sync clock detection: edges needed within a window
  localparam int SYNC_WIN_NS = 2000;
  localparam logic [7:0] SYNC_WIN_CYC = 8'(SYNC_WIN_NS * CLK_MHZ / 1000);
  localparam logic [2:0] SYNC_EDGES = 3'h4;
  // range encodings
  localparam logic [1:0] RANGE_1P25 = 2'h0;
  localparam logic [1:0] RANGE_2P5 = 2'h1;
  localparam logic [1:0] RANGE_5 = 2'h2;
  localparam logic [1:0] RANGE_10 = 2'h3;
  localparam logic [1:0] RANGE_DEF = RANGE_5;
  // range base and step in microvolts; 22 bits hold the 3.35 V top of the high range
  localparam logic [21:0] BASE_LO_UV = 22'h061a80;
  localparam logic [21:0] BASE_HI_UV = 22'h0c3500;
  localparam logic [21:0] STEP0_UV = 22'h0004e2;
  localparam logic [21:0] STEP1_UV = 22'h0009c4;
  localparam logic [21:0] STEP2_UV = 22'h001388;
  localparam logic [21:0] STEP3_UV = 22'h002710;
  // switching frequency codes in kHz
  localparam logic [11:0] FSW0_KHZ = 12'd1500;
  localparam logic [11:0] FSW1_KHZ = 12'd2250;
  localparam logic [11:0] FSW2_KHZ = 12'd2500;
  localparam logic [11:0] FSW3_KHZ = 12'd3000;
  // default setpoint codes by voltage strap
  localparam logic [7:0] VSET_GND = 8'h46;
  localparam logic [7:0] VSET_VIN = 8'h5f;
  localparam logic [6:0] ADDR_BASE = 7'h40; // arbitrary target address base
  localparam logic [1:0] SS_DEF = 2'h1;
  localparam logic [1:0] SLEW_DEF = 2'h0;

  typedef enum logic [2:0] {
    BSM_ST_MSB, BSM_ST_LSB, BSM_ST_IDLE, BSM_ST_SOFT, BSM_ST_RUN, BSM_ST_SLEW
  } bsm_state_e;

  typedef struct packed {
    logic       wrSetpoint;  // write strobe for setpoint code
    logic       wrControl;   // write strobe for range/slew/softstart/forced bit
    logic [7:0] setpoint;
    logic [1:0] range;
    logic [1:0] slew;
    logic [1:0] softstart;
    logic       forced;
  } bsm_host_s;

  typedef struct packed {
    logic [7:0] code;    // ramping setpoint code to the reference dac
    logic [1:0] range;   // range in use
    logic       refHigh; // 0.8 V reference selected
    logic [21:0] targetUv;
    logic       forcedPwm;
    logic       dcmOnly;
    logic       syncLock;
  } bsm_stage_s;
endpackage

// *** bsm_strap_model.sv ***
// strap resistor model: level seen by the sense buffer for a given strap code
module bsm_strap_model
(
  input  wire logic [1:0] strapCode,   // 0 gnd short, 1 res to gnd, 2 res to vin, 3 vin short
  input  wire logic       probe1Close, // pull-up probe closed
  input  wire logic       probe2Close, // pull-down probe closed
  output logic            level        // sensed pin level
);
  timeunit 1ns;
  timeprecision 100ps;
  // a resistor lets the closed probe win, a short always wins
  assign level = strapCode[1] ? (probe2Close ? strapCode[0] : 1'b1)
                              : (probe1Close ? strapCode[0] : 1'b0);
endmodule
